/* timer16_pkg.sv */
// Constants for the 16-bit timer/counter: register map, field layout, reset values.
// Assumes a 32-bit APB slave with one register per aligned word.
`default_nettype none
package timer16_pkg;
  localparam logic [11:0] addr_count_low    = 12'h000;
  localparam logic [11:0] addr_count_high   = 12'h004;
  localparam logic [11:0] addr_timer_control = 12'h008;
  localparam logic [11:0] addr_flags        = 12'h00c;
  localparam logic [11:0] addr_enables      = 12'h010;
  localparam logic [11:0] addr_aux_control  = 12'h014;
  localparam int bit_counter_on   = 0;
  localparam int bit_clk_src      = 1;
  localparam int bit_sync_dis     = 2;
  localparam int bit_ccp_sel_lo   = 3;
  localparam int bit_pre_lo       = 4;
  localparam int bit_pre_hi       = 5;
  localparam int bit_ccp_sel_hi   = 6;
  localparam int bit_wide         = 7;
  localparam int bit_overflow     = 1;
  localparam int bit_aux_osc      = 0;
  localparam logic [7:0]  control_reset = 8'h00;
  localparam logic [15:0] count_reset   = 16'h0000;
  localparam logic [15:0] count_max     = 16'hffff;
  localparam logic [1:0]  instr_div_last = 2'h3;
  localparam logic [3:0]  special_event_mode = 4'hb;
  typedef enum logic [1:0] {ext_wait_low, ext_armed} ext_state_e;
endpackage
`default_nettype wire

/* timer16_edge.sv */
// Rising-edge detector for the external count clock with first-edge suppression.
// Assumes a raw pin input; sync path uses three flops, the last two compared.
`timescale 1ns/1ps
`default_nettype none
module timer16_edge
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Control
  input  wire logic arm_clear,
  input  wire logic sync_bypass,
  // Pin
  input  wire logic ext_in,
  // Result
  output logic      ext_tick
);
  logic       s1;
  logic       s2;
  logic       s3;
  logic       level;
  logic       last_level;
  ext_state_e state;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
    end
    else if (clk_en)
    begin
      s1       <= ext_in;
      s2       <= s1;
      s3       <= s2;
    end
  end

  // Bypass still samples through two flops (s2); this fabric cannot count truly asynchronously
  always_comb
  begin
    if (sync_bypass)
      level = s2;
    else if (s2 == s3)
      level = s3;
    else
      level = last_level;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      last_level <= 1'b0;
      state      <= ext_wait_low;
    end
    else if (clk_en)
    begin
      last_level <= level;
      if (arm_clear)
        state <= ext_wait_low;
      else
        case (state)
          ext_wait_low:
            if (!level)
              state <= ext_armed;
          ext_armed:
            state <= ext_armed;
          default:
            state <= ext_wait_low;
        endcase
    end
  end

  assign ext_tick = (state == ext_armed) && level && !last_level && !arm_clear;
endmodule
`default_nettype wire

/* timer16.sv */
// 16-bit up-counting timer/counter with APB registers, prescaler and compare reset.
// Assumes one clock, synchronous reset and capture/compare units giving match flags.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer16
  import timer16_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External clock pin and auxiliary oscillator
  input  wire logic        ext_clock_pin,
  input  wire logic        aux_osc_clk,
  input  wire logic [1:0]  port_c_direction,
  input  wire logic [1:0]  port_c_pin_in,
  output logic [1:0]       port_c_dir_eff,
  output logic [1:0]       port_c_read,
  // Capture/compare units
  input  wire logic [3:0]  unit1_mode,
  input  wire logic        unit1_match,
  input  wire logic [3:0]  unit2_mode,
  input  wire logic        unit2_match,
  output logic             unit1_uses_this,
  output logic             unit2_uses_this,
  output logic [15:0]      timer_value,
  // Interrupt request
  output logic             overflow_irq
);
  logic [7:0]  timer_control;
  logic [15:0] count;
  logic [7:0]  high_buffer;
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic        aux_osc_enable;
  logic [1:0]  instr_div;
  logic [2:0]  prescale_cnt;
  logic        instr_tick;
  logic        ext_tick;
  logic        src_tick;
  logic        count_tick;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_low;
  logic        wr_high;
  logic        rd_low;
  logic        sev1;
  logic        sev2;
  logic        wrap;
  logic        wide_access_mode;
  logic        clock_source_select;
  logic        ext_sync_disable;
  logic        counter_on;
  logic [1:0]  prescale_select;
  logic [1:0]  capture_timebase_select;
  logic [15:0] next_count;
  logic [31:0] next_rdata;
  logic        addr_ok;
  logic        wr_control;
  logic        wr_flags;
  logic        wr_enables;
  logic        wr_aux;
  logic        rd_setup;
  logic        prescale_end;
  logic        count_running;
  logic        special_reset;
  logic        count_write;
  logic        overflow_set;
  logic        buffer_fill;
  logic        buffer_capture;
  logic        arm_clear;
  logic        ext_source;
  logic [7:0]  write_byte;
  logic [7:0]  live_high;
  logic [7:0]  high_view;

  assign wide_access_mode        = timer_control[bit_wide];
  assign clock_source_select     = timer_control[bit_clk_src];
  assign ext_sync_disable        = timer_control[bit_sync_dis];
  assign counter_on              = timer_control[bit_counter_on];
  assign prescale_select         = {timer_control[bit_pre_hi], timer_control[bit_pre_lo]};
  assign capture_timebase_select = {timer_control[bit_ccp_sel_hi], timer_control[bit_ccp_sel_lo]};

  function automatic logic [2:0] prescale_last(input logic [1:0] sel);
    prescale_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
    join_bytes = {hi, lo};
  endfunction

  // APB: zero wait states; writes take effect at the access edge, read data is registered at the setup edge
  assign pready  = 1'b1;
  assign acc     = psel && penable && clk_en;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign wr_low  = wr && is_addr(paddr, addr_count_low);
  assign wr_high = wr && is_addr(paddr, addr_count_high);
  assign rd_low  = rd && is_addr(paddr, addr_count_low);
  assign addr_ok = is_addr(paddr, addr_count_low) || is_addr(paddr, addr_count_high) ||
                   is_addr(paddr, addr_timer_control) || is_addr(paddr, addr_flags) ||
                   is_addr(paddr, addr_enables) || is_addr(paddr, addr_aux_control);
  // Unmapped reads return zero; pslverr tells software so
  assign pslverr = psel && penable && !addr_ok;

  // Per-register write strobes, all qualified by the access edge and clk_en
  assign write_byte  = pwdata[7:0];
  assign wr_control  = wr && is_addr(paddr, addr_timer_control);
  assign wr_flags    = wr && is_addr(paddr, addr_flags);
  assign wr_enables  = wr && is_addr(paddr, addr_enables);
  assign wr_aux      = wr && is_addr(paddr, addr_aux_control);
  // A wide-mode high write only fills the buffer, so it does not count as a counter write
  assign count_write = wr_low || (wr_high && !wide_access_mode);
  // Read data launched in the setup cycle stands for the whole access phase
  assign rd_setup    = psel && !penable && !pwrite && clk_en;

  // Buffer traffic exists only in wide mode
  assign buffer_fill    = wide_access_mode && wr_high;
  assign buffer_capture = wide_access_mode && rd_low;

  // Timebase routing
  assign unit1_uses_this = capture_timebase_select[1];
  assign unit2_uses_this = capture_timebase_select[1] || capture_timebase_select[0];
  assign sev1 = unit1_uses_this && (unit1_mode == special_event_mode) && unit1_match;
  assign sev2 = unit2_uses_this && (unit2_mode == special_event_mode) && unit2_match;
  assign special_reset = sev1 || sev2;
  assign live_high     = count[15:8];
  assign high_view     = wide_access_mode ? high_buffer : live_high;
  assign timer_value   = count;

  // Oscillator pins forced to inputs
  assign port_c_dir_eff = aux_osc_enable ? 2'h3 : port_c_direction;
  assign port_c_read    = aux_osc_enable ? 2'h0 : port_c_pin_in;

  // Re-arming on stop or source change makes the first edge after enabling wait for a low
  assign arm_clear  = !clock_source_select || !counter_on;
  assign ext_source = aux_osc_enable ? aux_osc_clk : ext_clock_pin;

  timer16_edge u_edge
  (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .arm_clear   (arm_clear),
    .sync_bypass (ext_sync_disable),
    .ext_in      (ext_source),
    .ext_tick    (ext_tick)
  );

  // Instruction cycle is a quarter of the core clock
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      instr_div <= 2'h0;
    else if (clk_en)
      instr_div <= instr_div + 2'h1;
  end
  assign instr_tick = (instr_div == instr_div_last);

  assign src_tick = clock_source_select ? ext_tick : instr_tick;
  // Gating here, not at the divider, keeps the instruction phase free-running
  assign count_running = counter_on && src_tick;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      prescale_cnt <= 3'h0;
    else if (clk_en)
    begin
      if (wr_low)
        prescale_cnt <= 3'h0;
      else if (count_running)
      begin
        if (prescale_end)
          prescale_cnt <= 3'h0;
        else
          prescale_cnt <= prescale_cnt + 3'h1;
      end
    end
  end
  assign prescale_end = (prescale_cnt >= prescale_last(prescale_select));
  assign count_tick   = count_running && prescale_end;

  assign wrap = count_tick && (count == count_max);

  always_comb
  begin
    next_count = count;
    // Write wins over special-event reset
    if (count_write)
    begin
      if (wr_low && wide_access_mode)
        next_count = join_bytes(high_buffer, write_byte);
      else if (wr_low)
        next_count = join_bytes(live_high, write_byte);
      else
        next_count = join_bytes(write_byte, count[7:0]);
    end
    else if (special_reset)
      next_count = count_reset;
    else if (count_tick)
      next_count = count + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      count <= count_reset;
    else if (clk_en)
      count <= next_count;
  end

  // High-byte buffer used only in wide mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      high_buffer <= 8'h00;
    else if (clk_en)
    begin
      if (buffer_fill)
        high_buffer <= write_byte;
      else if (buffer_capture)
        high_buffer <= live_high;
    end
  end

  // Control register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      timer_control <= control_reset;
    else if (wr_control)
      timer_control <= write_byte;
  end

  // Overflow interrupt enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      overflow_irq_enable <= 1'b0;
    else if (wr_enables)
      overflow_irq_enable <= pwdata[bit_overflow];
  end

  // Oscillator enable; the pin override follows it combinationally
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      aux_osc_enable <= 1'b0;
    else if (wr_aux)
      aux_osc_enable <= pwdata[bit_aux_osc];
  end

  // Wrap sets the flag; a special-event reset is no wrap, so unit 2 never sets it
  assign overflow_set = wrap && !count_write && !special_reset;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      overflow_flag <= 1'b0;
    else if (clk_en)
    begin
      // Hardware set wins over a software clear in the same cycle
      if (overflow_set)
        overflow_flag <= 1'b1;
      else if (wr_flags)
        overflow_flag <= pwdata[bit_overflow];
    end
  end

  assign overflow_irq = overflow_flag && overflow_irq_enable;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      addr_count_low:     next_rdata[7:0] = count[7:0];
      addr_count_high:    next_rdata[7:0] = high_view;
      addr_timer_control: next_rdata[7:0] = timer_control;
      addr_flags:         next_rdata[bit_overflow] = overflow_flag;
      addr_enables:       next_rdata[bit_overflow] = overflow_irq_enable;
      addr_aux_control:   next_rdata[bit_aux_osc] = aux_osc_enable;
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered in the setup cycle, valid through the access phase
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= next_rdata;
  end
endmodule
`default_nettype wire

/* timer16_asserts.sv */
// Checker for the 16-bit timer: count steps, compare reset, routing, pins.
// Assumes it is bound to timer16 and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module timer16_asserts
  import timer16_pkg::*;
(
  // Clock, reset, enable
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Pins, units, results
  input wire logic [1:0]  port_c_direction,
  input wire logic [1:0]  port_c_pin_in,
  input wire logic [1:0]  port_c_dir_eff,
  input wire logic [1:0]  port_c_read,
  input wire logic [3:0]  unit1_mode,
  input wire logic        unit1_match,
  input wire logic        unit2_match,
  input wire logic        unit1_uses_this,
  input wire logic        unit2_uses_this,
  input wire logic [15:0] timer_value,
  input wire logic        overflow_irq
);
  logic [7:0] ctrl;
  logic [7:0] wlo;
  logic       aux;
  logic       wr;
  logic       ev;
  assign wr = psel && penable && pwrite;
  assign ev = unit1_match || unit2_match;
  assign wlo = pwdata[7:0];
  // Shadow copies, so no hierarchical peeking is needed
  always_ff @(posedge core_clk)
    if (sys_rst)
      ctrl <= 8'h00;
    else if (wr && paddr == addr_timer_control)
      ctrl <= wlo;
  always_ff @(posedge core_clk)
    if (sys_rst)
      aux <= 1'b0;
    else if (wr && paddr == addr_aux_control)
      aux <= wlo[bit_aux_osc];
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_count_step: assert property (
    $changed(timer_value) && !$past(wr) |-> timer_value == $past(timer_value) + 16'h0001 || timer_value == 16'h0000)
    else $error("count moved by other than one");
  chk_special_reset: assert property (
    unit1_match && unit1_mode == special_event_mode && unit1_uses_this && clk_en && !wr |=> timer_value == 16'h0000)
    else $error("compare event did not clear count");
  chk_write_wins: assert property (
    wr && clk_en && paddr == addr_count_low && ev |=> timer_value[7:0] == $past(wlo))
    else $error("write lost to compare event");
  chk_timebase_route: assert property (
    unit1_uses_this == ctrl[bit_ccp_sel_hi] && unit2_uses_this == (ctrl[bit_ccp_sel_hi] || ctrl[bit_ccp_sel_lo]))
    else $error("timebase routing wrong");
  chk_stopped_hold: assert property (
    !ctrl[bit_counter_on] && !wr && !ev |=> $stable(timer_value))
    else $error("count moved while off");
  chk_tick_spacing: assert property (
    ctrl[1:0] == 2'b01 && $changed(timer_value) && !$past(wr) && !$past(ev)
    |=> ($stable(timer_value) || $past(wr) || $past(ev))[*3])
    else $error("internal ticks closer than four cycles");
  chk_irq_cause: assert property (
    $rose(overflow_irq) |-> $past(timer_value) == count_max || $past(timer_value, 2) == count_max || $past(wr))
    else $error("interrupt without wrap or write");
  chk_osc_pins: assert property (
    aux ? port_c_dir_eff == 2'b11 && port_c_read == 2'b00
        : port_c_dir_eff == port_c_direction && port_c_read == port_c_pin_in)
    else $error("oscillator pin override wrong");
  cover property (unit1_match && unit1_uses_this);
  cover property (wr && ev);
  cover property ($rose(overflow_irq));
endmodule
bind timer16 timer16_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .port_c_direction(port_c_direction),
  .port_c_pin_in(port_c_pin_in), .port_c_dir_eff(port_c_dir_eff), .port_c_read(port_c_read),
  .unit1_mode(unit1_mode), .unit1_match(unit1_match), .unit2_match(unit2_match),
  .unit1_uses_this(unit1_uses_this), .unit2_uses_this(unit2_uses_this), .timer_value(timer_value),
  .overflow_irq(overflow_irq));
`default_nettype wire

/* timer16_partner.sv */
// Far-side model: external count clock source and two compare units.
// Assumes the units compare the live count and obey the routing outputs.
`timescale 1ns/1ps
`default_nettype none
module timer16_partner #(
  parameter int half = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Count clock
  input  wire logic        ext_run,
  output logic             ext_clock_pin,
  // Compare units
  input  wire logic [15:0] timer_value,
  input  wire logic        unit1_uses_this,
  input  wire logic        unit2_uses_this,
  input  wire logic [15:0] unit1_cmp,
  input  wire logic [15:0] unit2_cmp,
  output logic             unit1_match,
  output logic             unit2_match
);
  int         cnt;
  logic [1:0] eq;
  logic [1:0] eq_d;
  assign eq = {unit2_uses_this && timer_value == unit2_cmp, unit1_uses_this && timer_value == unit1_cmp};
  // Pin stands at its last level between bursts, like a gated source
  always_ff @(posedge core_clk)
  begin
    cnt <= (ext_run && cnt < half - 1) ? cnt + 1 : 0;
    if (sys_rst)
      ext_clock_pin <= 1'b0;
    else if (ext_run && cnt == half - 1)
      ext_clock_pin <= !ext_clock_pin;
  end
  // One pulse when equality first appears; a held count must not retrigger
  always_ff @(posedge core_clk)
  begin
    eq_d <= eq;
    {unit2_match, unit1_match} <= sys_rst ? 2'b00 : eq & ~eq_d;
  end
endmodule
`default_nettype wire

/* timer16_tb.sv */
// Self-checking bench for timer16 over APB with the far-side model.
// Assumes zero-wait APB and the register map of timer16_pkg.
`timescale 1ns/1ps
`default_nettype none
module timer16_tb;
  import timer16_pkg::*;
  logic        core_clk, sys_rst, clk_en, psel, penable, pwrite, run, er;
  logic        pready, pslverr, pin, mt1, mt2, u1, u2, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] c1, c2, mx, tv;
  logic [3:0]  m1, m2;
  logic [1:0]  dir, pin_in, dir_eff, pread;
  int          num_errors, num_checks, cyc, i;
  timer16 DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_clock_pin(pin), .aux_osc_clk(pin), .port_c_direction(dir), .port_c_pin_in(pin_in),
    .port_c_dir_eff(dir_eff), .port_c_read(pread), .unit1_mode(m1), .unit1_match(mt1), .unit2_mode(m2),
    .unit2_match(mt2), .unit1_uses_this(u1), .unit2_uses_this(u2), .timer_value(tv), .overflow_irq(irq));
  timer16_partner u_far (.core_clk(core_clk), .sys_rst(sys_rst), .ext_run(run), .ext_clock_pin(pin),
    .timer_value(tv), .unit1_uses_this(u1), .unit2_uses_this(u2), .unit1_cmp(c1), .unit2_cmp(c2),
    .unit1_match(mt1), .unit2_match(mt2));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
    idle(1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h0);
    idle(1);
    check(rd, {24'h0, e});
  endtask
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the roughly 1500 cycles the tests need
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  initial
  begin
    {sys_rst, clk_en, psel, penable, pwrite, run, paddr, pwdata} = {3'b110, 47'h0};
    {dir, pin_in, m1, m2, c1, c2} = {4'b0110, 8'hbb, 16'h5, 16'h10};
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(addr_timer_control, control_reset);
    rdc(12'h018, 8'h00);
    check(er, 1'b1);
    wr(addr_count_high, 8'h5a);
    wr(addr_count_low, 8'h34);
    check(tv, 16'h5a34);
    rdc(addr_count_high, 8'h5a);
    wr(addr_timer_control, 8'h80);
    wr(addr_count_high, 8'hab);
    check(tv, 16'h5a34);
    wr(addr_count_low, 8'hcd);
    check(tv, 16'habcd);
    wr(addr_count_high, 8'h11);
    rdc(addr_count_low, 8'hcd);
    rdc(addr_count_high, 8'hab);
    $display("access tests done");
    wr(addr_timer_control, 8'h01);
    wr(addr_count_high, 8'hff);
    wr(addr_count_low, 8'hfc);
    idle(30);
    rdc(addr_flags, 8'h02);
    check(irq, 1'b0);
    wr(addr_enables, 8'h02);
    check(irq, 1'b1);
    wr(addr_flags, 8'h00);
    check(irq, 1'b0);
    $display("overflow test done");
    for (i = 0; i < 4; i++)
    begin
      wr(addr_timer_control, 8'h01 | 8'(i << 4));
      wr(addr_count_low, 8'h00);
      idle(32 << i);
      check(tv == 16'd7 || tv == 16'd8, 1'b1);
    end
    wr(addr_timer_control, 8'h00);
    mx = tv;
    idle(20);
    check(tv, mx);
    $display("rate tests done");
    run <= 1'b1;
    idle(4);
    run <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      wr(addr_aux_control, 8'(i == 2));
      wr(addr_timer_control, i == 1 ? 8'h07 : 8'h03);
      wr(addr_count_low, 8'h00);
      run <= 1'b1;
      idle(80);
      run <= 1'b0;
      idle(8);
      check(tv, 16'd10);
    end
    check(dir_eff, 2'b11);
    check(pread, 2'b00);
    wr(addr_aux_control, 8'h00);
    check(dir_eff, dir);
    check(pread, pin_in);
    $display("external tests done");
    for (i = 0; i < 4; i++)
    begin
      wr(addr_timer_control, {1'b0, i[1], 2'b00, i[0], 3'b001});
      wr(addr_count_low, 8'h00);
      mx = 16'h0;
      repeat (120)
      begin
        @(posedge core_clk);
        if (tv > mx)
          mx = tv;
      end
      check(u1, i[1]);
      check(u2, i[1] | i[0]);
      check(i[1] ? mx == 16'd5 : i[0] ? mx == 16'd16 : mx > 16'd16, 1'b1);
    end
    c2 <= 16'hffff;
    wr(addr_timer_control, 8'h09);
    wr(addr_count_high, 8'hff);
    wr(addr_count_low, 8'hf0);
    idle(80);
    rdc(addr_flags, 8'h00);
    c1 <= 16'h0007;
    wr(addr_timer_control, 8'h40);
    wr(addr_count_low, 8'h00);
    xfer(addr_count_low, 1'b1, 32'h07);
    xfer(addr_count_low, 1'b1, 32'h09);
    idle(3);
    check(tv[7:0], 8'h09);
    $display("compare tests done");
    give_verdict;
  end
endmodule
`default_nettype wire
